// ===== iws_params.svh
// Clock rate, wake and watchdog times in microseconds, field positions and pin reset level of the two-wire wake port
`ifndef IWS_PARAMS_SVH
`define IWS_PARAMS_SVH

// Clock rate in MHz
`define IWS_CLK_MHZ     50
// Wake-low time in microseconds
`define IWS_WLO_US      60
// Wake-high delay in microseconds
`define IWS_WHI_US      1500
// Watchdog interval in microseconds
`define IWS_WDT_US      1300000
// Bits in one byte before the acknowledge clock
`define IWS_BYTE_BITS   4'h8
// Direction bit of the address byte
`define IWS_RW_BIT      0
// Threshold select bit of the address byte
`define IWS_TTL_BIT     3
// Reset level of the sampled pins
`define IWS_PIN_IDLE    1'h1

`endif

// ===== iws_pkg.sv
// Types shared by the two-wire wake port
package iws_pkg;

	typedef enum logic [2:0] {
		IWS_SLEEP,
		IWS_IDLE,
		IWS_WLOW,
		IWS_WHIGH,
		IWS_AWAKE
	} iws_pwr_t;

	typedef enum logic [2:0] {
		PH_IDLE,
		PH_ADDR,
		PH_AACK,
		PH_DATA,
		PH_DACK,
		PH_IGN
	} iws_ph_t;

	typedef struct packed {
		logic [7:0] data;
		logic       last;
	} iws_rx_t;

endpackage

// ===== iws_sync.sv
// Two-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ps
`include "iws_params.svh"

module iws_sync #(
	parameter int WIDTH = 2
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             resetn,
	// Levels
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);

	logic [WIDTH-1:0] meta_q;

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			always_ff @(posedge clk or negedge resetn) begin
				if (!resetn) begin
					meta_q[i] <= `IWS_PIN_IDLE;
					q[i]      <= `IWS_PIN_IDLE;
				end else begin
					meta_q[i] <= d[i];
					q[i]      <= meta_q[i];
				end
			end
		end
	endgenerate

endmodule

// ===== iws_port.sv
// Two-wire target port with wake detection, byte counting and watchdog
`timescale 1ns/1ps
`include "iws_params.svh"

module iws_port #(
	parameter int WHI_CYC = `IWS_WHI_US * `IWS_CLK_MHZ,
	parameter int WDT_CYC = `IWS_WDT_US * `IWS_CLK_MHZ
) (
	// Clock and reset
	input  wire logic            CLK,
	input  wire logic            RESETN,
	// Bus pins
	input  wire logic            SCL_I,
	input  wire logic            SDA_I,
	output logic                 SDA_O,
	output logic                 SDA_OE,
	// Configuration
	input  wire logic [7:0]      ADDR_CFG,
	output logic                 TTL_SEL,
	// Core requests
	input  wire logic            SLEEP_REQ,
	input  wire logic            IDLE_REQ,
	input  wire logic            EXEC_DONE,
	// Core status
	output logic                 AWAKE,
	output logic                 BUSY,
	output logic                 EXEC_START,
	output logic                 WDT_EXPIRED,
	// Received bytes
	output iws_pkg::iws_rx_t     RX,
	output logic                 RX_VALID
);

	localparam int WLO_CYC = `IWS_WLO_US * `IWS_CLK_MHZ;

	logic [1:0]        pins_s;
	logic              scl;
	logic              sda;
	logic              scl_p_q;
	logic              sda_p_q;
	logic              scl_en_q;
	logic              scl_rise;
	logic              scl_fall;
	logic              start_ev;
	logic              stop_ev;
	iws_pkg::iws_pwr_t pwr_q;
	iws_pkg::iws_ph_t  ph_q;
	logic [31:0]       wcnt_q;
	logic              ret_idle_q;
	logic [31:0]       wdt_q;
	logic              wdt_hit;
	logic [3:0]        bit_q;
	logic [7:0]        sh_q;
	logic              rd_q;
	logic              addr_ok;
	logic              byte_done;
	logic              take;
	logic              last;
	logic [7:0]        cnt_q;
	logic [7:0]        need_q;
	logic              full_q;
	logic              busy_q;
	logic              exec_go;
	logic              vol_clr;
	logic              sda_o_q;
	logic              sda_oe_q;
	logic              awake_q;
	logic              exec_q;
	logic              wdt_exp_q;
	logic              ttl_q;
	iws_pkg::iws_rx_t  rx_q;
	logic              rx_v_q;

	// Pin levels enter the clock domain here
	// oversampled bus edges
	iws_sync #(
		.WIDTH (2)
	) u_sync (
		.clk    (CLK),
		.resetn (RESETN),
		.d      ({SCL_I, SDA_I}),
		.q      (pins_s)
	);

	assign scl = pins_s[1];
	assign sda = pins_s[0];

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			scl_p_q <= `IWS_PIN_IDLE;
			sda_p_q <= `IWS_PIN_IDLE;
		end else begin
			scl_p_q <= scl;
			sda_p_q <= sda;
		end
	end

	assign scl_rise = scl_en_q & scl & ~scl_p_q;
	assign scl_fall = scl_en_q & ~scl & scl_p_q;
	assign start_ev = scl_en_q & scl & scl_p_q & sda_p_q & ~sda;
	assign stop_ev  = scl_en_q & scl & scl_p_q & ~sda_p_q & sda;

	assign wdt_hit = (pwr_q == iws_pkg::IWS_AWAKE) && !busy_q && (wdt_q >= WDT_CYC - 1);
	assign vol_clr = (pwr_q == iws_pkg::IWS_SLEEP);

	// Power states and wake timing
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			pwr_q      <= iws_pkg::IWS_SLEEP;
			wcnt_q     <= 32'h0;
			ret_idle_q <= 1'h0;
		end else begin
			case (pwr_q)
				iws_pkg::IWS_SLEEP, iws_pkg::IWS_IDLE: begin
					wcnt_q <= 32'h0;
					if (!sda) begin
						pwr_q      <= iws_pkg::IWS_WLOW;
						ret_idle_q <= (pwr_q == iws_pkg::IWS_IDLE);
					end
				end
				iws_pkg::IWS_WLOW: begin
					if (sda) begin
						wcnt_q <= 32'h0;
						if (wcnt_q >= WLO_CYC) begin
							pwr_q <= iws_pkg::IWS_WHIGH;
						end else if (ret_idle_q) begin
							pwr_q <= iws_pkg::IWS_IDLE;
						end else begin
							pwr_q <= iws_pkg::IWS_SLEEP;
						end
					end else if (wcnt_q < WLO_CYC) begin
						wcnt_q <= wcnt_q + 32'h1;
					end
				end
				iws_pkg::IWS_WHIGH: begin
					if (wcnt_q >= WHI_CYC - 1) begin
						pwr_q  <= iws_pkg::IWS_AWAKE;
						wcnt_q <= 32'h0;
					end else begin
						wcnt_q <= wcnt_q + 32'h1;
					end
				end
				iws_pkg::IWS_AWAKE: begin
					if (wdt_hit || SLEEP_REQ) begin
						pwr_q <= iws_pkg::IWS_SLEEP;
					end else if (IDLE_REQ) begin
						pwr_q <= iws_pkg::IWS_IDLE;
					end
				end
				default: begin
					pwr_q <= iws_pkg::IWS_SLEEP;
				end
			endcase
		end
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			scl_en_q <= 1'h0;
		end else begin
			scl_en_q <= (pwr_q == iws_pkg::IWS_WHIGH) || (pwr_q == iws_pkg::IWS_AWAKE);
		end
	end

	// Watchdog runs while awake and not executing
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			wdt_q     <= 32'h0;
			wdt_exp_q <= 1'h0;
		end else begin
			wdt_exp_q <= wdt_hit;
			if (pwr_q != iws_pkg::IWS_AWAKE || busy_q || wdt_hit) begin
				wdt_q <= 32'h0;
			end else begin
				wdt_q <= wdt_q + 32'h1;
			end
		end
	end

	assign addr_ok   = (sh_q[7:1] == ADDR_CFG[7:1]);
	assign byte_done = scl_fall && !start_ev && !stop_ev && (bit_q == `IWS_BYTE_BITS);
	assign take      = byte_done && (ph_q == iws_pkg::PH_DATA) && !busy_q && !full_q;
	assign last      = (cnt_q == 8'h0) ? (sh_q <= 8'h1) : ((cnt_q + 8'h1) == need_q);

	// Bit and byte framing, acknowledge drive
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			ph_q     <= iws_pkg::PH_IDLE;
			bit_q    <= 4'h0;
			sh_q     <= 8'h0;
			rd_q     <= 1'h0;
			sda_oe_q <= 1'h0;
		end else if (!scl_en_q) begin
			ph_q     <= iws_pkg::PH_IDLE;
			bit_q    <= 4'h0;
			sda_oe_q <= 1'h0;
		end else if (start_ev) begin
			ph_q     <= iws_pkg::PH_ADDR;
			bit_q    <= 4'h0;
			sda_oe_q <= 1'h0;
		end else if (stop_ev) begin
			ph_q     <= iws_pkg::PH_IDLE;
			sda_oe_q <= 1'h0;
		end else begin
			case (ph_q)
				iws_pkg::PH_ADDR, iws_pkg::PH_DATA: begin
					if (scl_rise && bit_q < `IWS_BYTE_BITS) begin
						sh_q  <= {sh_q[6:0], sda};
						bit_q <= bit_q + 4'h1;
					end else if (byte_done) begin
						bit_q <= 4'h0;
						if (ph_q == iws_pkg::PH_ADDR) begin
							rd_q <= sh_q[`IWS_RW_BIT];
							if (addr_ok && !busy_q) begin
								ph_q     <= iws_pkg::PH_AACK;
								sda_oe_q <= 1'h1;
							end else begin
								ph_q <= iws_pkg::PH_IGN;
							end
						end else begin
							ph_q     <= iws_pkg::PH_DACK;
							sda_oe_q <= take;
						end
					end
				end
				iws_pkg::PH_AACK: begin
					if (scl_fall) begin
						sda_oe_q <= 1'h0;
						ph_q     <= rd_q ? iws_pkg::PH_IGN : iws_pkg::PH_DATA;
					end
				end
				iws_pkg::PH_DACK: begin
					if (scl_fall) begin
						ph_q     <= sda_oe_q ? iws_pkg::PH_DATA : iws_pkg::PH_IGN;
						sda_oe_q <= 1'h0;
					end
				end
				iws_pkg::PH_IGN, iws_pkg::PH_IDLE: begin
					sda_oe_q <= 1'h0;
				end
				default: begin
					ph_q     <= iws_pkg::PH_IDLE;
					sda_oe_q <= 1'h0;
				end
			endcase
		end
	end

	assign exec_go = full_q && !busy_q
		&& ((ph_q == iws_pkg::PH_DACK && scl_fall) || stop_ev);

	// Command byte count, first byte gives the total
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			cnt_q  <= 8'h0;
			need_q <= 8'h0;
			full_q <= 1'h0;
		end else if (vol_clr || wdt_hit || (busy_q && EXEC_DONE)) begin
			cnt_q  <= 8'h0;
			need_q <= 8'h0;
			full_q <= 1'h0;
		end else if (take) begin
			cnt_q  <= cnt_q + 8'h1;
			full_q <= last;
			if (cnt_q == 8'h0) begin
				need_q <= sh_q;
			end
		end
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			busy_q <= 1'h0;
			exec_q <= 1'h0;
		end else begin
			exec_q <= exec_go;
			// Start of a new command wins over a stray done pulse
			if (vol_clr) begin
				busy_q <= 1'h0;
			end else if (exec_go) begin
				busy_q <= 1'h1;
			end else if (EXEC_DONE) begin
				busy_q <= 1'h0;
			end
		end
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			rx_q   <= '0;
			rx_v_q <= 1'h0;
		end else begin
			rx_v_q <= take;
			if (take) begin
				rx_q.data <= sh_q;
				rx_q.last <= last;
			end
		end
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			sda_o_q <= 1'h0;
			ttl_q   <= 1'h0;
			awake_q <= 1'h0;
		end else begin
			sda_o_q <= 1'h0;
			ttl_q   <= ADDR_CFG[`IWS_TTL_BIT];
			awake_q <= (pwr_q == iws_pkg::IWS_AWAKE);
		end
	end

	assign SDA_O       = sda_o_q;
	assign SDA_OE      = sda_oe_q;
	assign TTL_SEL     = ttl_q;
	assign AWAKE       = awake_q;
	assign BUSY        = busy_q;
	assign EXEC_START  = exec_q;
	assign WDT_EXPIRED = wdt_exp_q;
	assign RX          = rx_q;
	assign RX_VALID    = rx_v_q;

	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RESETN);

	chk_sda_low_only: assert property (SDA_OE |-> !SDA_O)
		else $error("data driven high");
	chk_asleep_silent: assert property (
		(pwr_q != iws_pkg::IWS_AWAKE && pwr_q != iws_pkg::IWS_WHIGH) ##1 1'b1 |-> !scl_en_q
	)
		else $error("clock enabled while asleep");
	chk_wake_low_time: assert property (
		pwr_q == iws_pkg::IWS_WHIGH && $past(pwr_q) == iws_pkg::IWS_WLOW
		|-> $past(wcnt_q) >= WLO_CYC
	)
		else $error("woke before wake-low time");
	chk_clock_enabled: assert property (
		pwr_q == iws_pkg::IWS_WHIGH |=> scl_en_q
	)
		else $error("clock not enabled during wake-high");
	chk_wake_ignored: assert property (
		pwr_q == iws_pkg::IWS_AWAKE && !wdt_hit && !SLEEP_REQ && !IDLE_REQ
		|=> pwr_q == iws_pkg::IWS_AWAKE
	)
		else $error("awake state left without cause");
	chk_mismatch_quiet: assert property (
		byte_done && ph_q == iws_pkg::PH_ADDR && !addr_ok |=> !SDA_OE [*2]
	)
		else $error("drove bus on foreign address");
	chk_busy_nack: assert property (
		byte_done && ph_q == iws_pkg::PH_ADDR && busy_q |=> !SDA_OE
	)
		else $error("busy device acknowledged address");
	chk_ack_own: assert property (
		byte_done && ph_q == iws_pkg::PH_ADDR && addr_ok && !busy_q
		|=> SDA_OE && ph_q == iws_pkg::PH_AACK
	)
		else $error("own address not acknowledged");
	chk_exec_on_count: assert property (
		exec_go |-> full_q && (cnt_q == need_q || cnt_q == 8'h1) ##1 EXEC_START && BUSY
	)
		else $error("execution without full count");
	chk_stop_ends: assert property (stop_ev |=> ph_q == iws_pkg::PH_IDLE && !SDA_OE)
		else $error("stop did not end transfer");
	chk_wdt_sleep: assert property (
		wdt_hit |=> pwr_q == iws_pkg::IWS_SLEEP && WDT_EXPIRED ##1 !AWAKE
	)
		else $error("watchdog did not reset");

	cov_wake_done: cover property (pwr_q == iws_pkg::IWS_WHIGH ##1 pwr_q == iws_pkg::IWS_AWAKE);
	cov_exec: cover property (EXEC_START);
	cov_busy_nack: cover property (byte_done && ph_q == iws_pkg::PH_ADDR && busy_q && addr_ok);
	cov_wdt: cover property (WDT_EXPIRED);

endmodule

// ===== iws_mst_model.sv
// Bus master model driving the two-wire port from the far side
`timescale 1ns/1ps

module iws_mst_model (
	// Clock
	input  wire logic clk,
	// Bus
	output logic      scl,
	output logic      sda_oe,
	input  wire logic sda
);
	initial begin
		scl = 1'b1;
		sda_oe = 1'b0;
	end

	task automatic hc(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic wake(input int n);
		@(posedge clk) sda_oe <= 1'b1;
		hc(n);
		sda_oe <= 1'b0;
		hc(4);
	endtask

	task automatic start();
		if (!scl) begin
			@(posedge clk) sda_oe <= 1'b0;
			hc(3);
			scl <= 1'b1;
			hc(4);
		end
		@(posedge clk) sda_oe <= 1'b1;
		hc(4);
		scl <= 1'b0;
	endtask

	// open drain, data moves while clock low
	task automatic bitx(input logic b, output logic r);
		@(posedge clk) sda_oe <= !b;
		hc(3);
		scl <= 1'b1;
		hc(4);
		r = sda;
		scl <= 1'b0;
	endtask

	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bitx(d[i], r);
		end
		bitx(1'b1, ack);
	endtask

	task automatic stop();
		@(posedge clk) sda_oe <= 1'b1;
		hc(3);
		scl <= 1'b1;
		hc(4);
		sda_oe <= 1'b0;
		hc(4);
	endtask
endmodule

// ===== tb.sv
// Self-checking bench of the two-wire wake port
`timescale 1ns/1ps

module tb;
	localparam int WHI = 50;
	localparam int WDT = 10000;
	logic             clk = 1'b0;
	logic             resetn = 1'b0;
	logic             sleep_req;
	logic             idle_req;
	logic             exec_done;
	logic [7:0]       cfg;
	logic [7:0]       seed = 8'h0B;
	logic [7:0]       d [3];
	logic             scl, m_oe, sda_w, ack;
	logic             sda_o, sda_oe, ttl_sel, awake, busy, exec_start, wdt_exp, rx_valid;
	iws_pkg::iws_rx_t rx;
	iws_pkg::iws_rx_t rxq [$];
	int               bad_count = 0;
	int               checked = 0;
	int               oe_cnt = 0;
	int               ex_cnt = 0;
	int               n, o;

	always #10 clk = ~clk;

	// Wired-and data line with pull-up
	assign sda_w = (m_oe || (sda_oe && !sda_o)) ? 1'b0 : 1'b1;

	always @(posedge clk) begin
		if (sda_oe) oe_cnt++;
		if (exec_start) ex_cnt++;
		if (rx_valid) rxq.push_back(rx);
	end

	iws_mst_model u_iws_mst_model (.clk(clk), .scl(scl), .sda_oe(m_oe), .sda(sda_w));

	iws_port #(.WHI_CYC(WHI), .WDT_CYC(WDT)) u_iws_port (
		.CLK(clk), .RESETN(resetn), .SCL_I(scl), .SDA_I(sda_w), .SDA_O(sda_o),
		.SDA_OE(sda_oe), .ADDR_CFG(cfg), .TTL_SEL(ttl_sel), .SLEEP_REQ(sleep_req),
		.IDLE_REQ(idle_req), .EXEC_DONE(exec_done), .AWAKE(awake), .BUSY(busy),
		.EXEC_START(exec_start), .WDT_EXPIRED(wdt_exp), .RX(rx), .RX_VALID(rx_valid)
	);

	function automatic logic [7:0] lfsr(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction

	task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// Bounded wait on awake (0) or watchdog pulse (1)
	task automatic wait_sig(input int sel, input int lim, output int cnt);
		cnt = 0;
		while ((sel ? wdt_exp : awake) !== 1'b1 && cnt < lim) begin
			@(posedge clk);
			#1;
			cnt++;
		end
		if (cnt >= lim) begin
			check("wait_bound", 1'b0, 1'b1);
			report_and_stop();
		end
	endtask

	task automatic addr_only(input logic [7:0] a, output logic k);
		u_iws_mst_model.start();
		u_iws_mst_model.wbyte(a, k);
		u_iws_mst_model.stop();
	endtask

	// Core request pulse: 0 idle, 1 sleep, 2 done
	task automatic pulse(input int k);
		@(posedge clk);
		idle_req <= (k == 0);
		sleep_req <= (k == 1);
		exec_done <= (k == 2);
		@(posedge clk);
		{idle_req, sleep_req, exec_done} <= 3'h0;
	endtask

	task automatic wake_up();
		u_iws_mst_model.wake(3100);
		wait_sig(0, 4000, n);
	endtask

	initial begin
		{idle_req, sleep_req, exec_done} = 3'h0;
		cfg = lfsr(seed) & 8'hFE;
		seed = cfg;
		repeat (10) @(posedge clk);
		check("awake_rst", awake, 1'b0);
		check("oe_rst", sda_oe, 1'b0);
		resetn <= 1'b1;
		repeat (3) @(posedge clk);
		check("ttl_sel", ttl_sel, cfg[3]);
		$display("test reset done");
		o = oe_cnt;
		addr_only(cfg, ack);
		check("asleep_ack", ack, 1'b1);
		u_iws_mst_model.wake(200);
		u_iws_mst_model.hc(200);
		check("short_low", awake, 1'b0);
		check("asleep_oe", oe_cnt - o, 0);
		$display("test asleep done");
		wake_up();
		check("wake_min", n >= WHI - 4, 1'b1);
		check("wake_max", n <= WHI + 8, 1'b1);
		$display("test wake done");
		for (int i = 0; i < 4; i++) begin
			seed = lfsr(seed);
			d[0] = seed;
			if (d[0][7:1] == cfg[7:1]) d[0][7] = ~d[0][7];
			o = oe_cnt;
			addr_only(d[0], ack);
			check("miss_ack", ack, 1'b1);
			check("miss_oe", oe_cnt - o, 0);
		end
		$display("test address done");
		d[0] = 8'h03;
		for (int i = 1; i < 3; i++) begin
			seed = lfsr(seed);
			d[i] = seed;
		end
		u_iws_mst_model.start();
		u_iws_mst_model.wbyte(cfg, ack);
		check("addr_ack", ack, 1'b0);
		for (int i = 0; i < 3; i++) begin
			u_iws_mst_model.wbyte(d[i], ack);
			check("data_ack", ack, 1'b0);
		end
		u_iws_mst_model.hc(6);
		check("exec_cnt", ex_cnt, 1);
		check("busy", busy, 1'b1);
		u_iws_mst_model.wbyte(8'hA5, ack);
		check("extra_nack", ack, 1'b1);
		u_iws_mst_model.stop();
		addr_only(cfg | 8'h01, ack);
		check("busy_nack", ack, 1'b1);
		check("rx_count", rxq.size(), 3);
		for (int i = 0; i < 3 && i < rxq.size(); i++) begin
			check("rx_byte", rxq[i], {d[i], i == 2});
		end
		pulse(2);
		u_iws_mst_model.hc(3);
		check("busy_clr", busy, 1'b0);
		check("exec_once", ex_cnt, 1);
		addr_only(cfg | 8'h01, ack);
		check("rd_ack", ack, 1'b0);
		$display("test command done");
		u_iws_mst_model.wake(3100);
		check("rewake", awake, 1'b1);
		addr_only(cfg, ack);
		check("rewake_ack", ack, 1'b0);
		$display("test rewake done");
		wait_sig(1, 12000, n);
		u_iws_mst_model.hc(3);
		check("wdt_sleep", awake, 1'b0);
		addr_only(cfg, ack);
		check("wdt_ack", ack, 1'b1);
		$display("test watchdog done");
		for (int k = 0; k < 2; k++) begin
			wake_up();
			seed = lfsr(seed);
			@(posedge clk) cfg <= seed & 8'hFE;
			u_iws_mst_model.start();
			u_iws_mst_model.wbyte(cfg, ack);
			check("cfg_ack", ack, 1'b0);
			u_iws_mst_model.wbyte(8'(k), ack);
			check("one_ack", ack, 1'b0);
			u_iws_mst_model.stop();
			check("one_exec", ex_cnt, 2 + k);
			check("one_last", rxq[rxq.size() - 1].last, 1'b1);
			pulse(2);
			pulse(k);
			u_iws_mst_model.hc(3);
			check("ttl_req", ttl_sel, cfg[3]);
			check("req_awake", awake, 1'b0);
			addr_only(cfg, ack);
			check("req_ack", ack, 1'b1);
		end
		$display("test requests done");
		report_and_stop();
	end
endmodule
